// ---- src/casgen_sig_framer.v ----
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "casgen_defines.vh"

// ----------------------------------------
// Packet FIFO
// ----------------------------------------
module casgen_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Fill side
    input  wire             s_valid,
    output wire             s_ready,
    input  wire [WIDTH-1:0] s_data,
    // Drain side
    output wire             m_valid,
    input  wire             m_ready,
    output wire [WIDTH-1:0] m_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr;
    reg [AW-1:0]    rptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign s_ready = (count != DEPTH[AW:0]);
    assign m_valid = (count != {(AW+1){1'b0}});
    assign m_data  = mem[rptr];
    assign push    = s_valid & s_ready;
    assign pop     = m_valid & m_ready;

    // Storage has no reset; only pointers and count need a defined value
    always @(posedge pclk) begin
        if (push) begin
            mem[wptr] <= s_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr  <= {AW{1'b0}};
            rptr  <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // casgen_fifo

// ----------------------------------------
// Signaling packet framer
// ----------------------------------------
module casgen_sig_framer #(
    parameter SLOTS     = 24,
    parameter MS_CYCLES = `CASGEN_MS_CYCLES,
    parameter TS_CYCLES = `CASGEN_TS_CYCLES,
    parameter PBITS     = ((SLOTS + 1) / 2) * 8,
    parameter WBITS     = 72 + PBITS
) (
    // Clock and reset
    input  wire               pclk,
    input  wire               presetn,
    // APB slave
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [7:0]         paddr,
    input  wire [31:0]        pwdata,
    output reg  [31:0]        prdata,
    output reg                pready,
    output reg                pslverr,
    // Line status and signaling in
    input  wire [4*SLOTS-1:0] cas_signal_bits,
    input  wire               loss_of_frames,
    input  wire               remote_frame_loss,
    // Data packet header request
    input  wire               data_pkt_req,
    output reg                data_hdr_valid,
    output reg  [15:0]        data_hdr_seq,
    output reg  [31:0]        data_hdr_ts,
    output reg  [7:0]         data_hdr_tos,
    output reg  [6:0]         data_hdr_pt,
    // Shared flow identity
    output reg                flow_rtp_en,
    output reg  [31:0]        flow_dst_ip,
    output reg  [31:0]        flow_src_ip,
    output reg  [15:0]        flow_dst_port,
    // Signaling packet stream
    output reg                sig_valid,
    input  wire               sig_ready,
    output reg  [WBITS-1:0]   sig_data,
    // Received signaling
    input  wire               rx_valid,
    input  wire [6:0]         rx_pt,
    input  wire [PBITS-1:0]   rx_payload,
    output reg  [4*SLOTS-1:0] rx_cas_bits
);
    localparam ST_IDLE  = 1'b0;
    localparam ST_BURST = 1'b1;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg              enable;
    reg              ptchk;
    reg  [7:0]       data_tos;
    reg  [7:0]       sig_tos;
    reg  [6:0]       data_pt;
    reg  [6:0]       sig_pt;
    reg  [6:0]       peer_pt;
    reg  [15:0]      rpt_ms;
    reg  [15:0]      ref_ms;
    reg              cfg_err;
    reg  [7:0]       bad_cnt;
    reg  [15:0]      data_seq;
    reg  [15:0]      sig_seq;
    reg  [31:0]      ts;
    reg  [31:0]      ms_div;
    reg  [31:0]      ts_div;
    reg              ms_tick;
    reg              setup_pulse;
    reg  [4*SLOTS-1:0] cas_prev;
    reg              lof_prev;
    reg              rfl_prev;
    reg              state;
    reg  [1:0]       left;
    reg              due;
    reg  [15:0]      ivl;
    reg  [15:0]      ref_cnt;
    reg  [4*SLOTS-1:0] snap;
    wire [PBITS-1:0] pay;
    reg              rx_ok;
    wire             wr_en;
    wire             rd_setup;
    wire             event_now;
    wire             push;
    wire             fifo_ready;
    wire             f_valid;
    wire [WBITS-1:0] f_data;
    wire [WBITS-1:0] word;
    wire             pt_write_bad;
    integer          k;

    // Known register offsets
    function mapped;
        input [7:0] a;
        begin
            mapped = (a <= `CASGEN_ADDR_PORT) && (a[1:0] == 2'h0);
        end
    endfunction

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign wr_en    = psel & penable & pready & pwrite & mapped(paddr);
    assign rd_setup = psel & ~penable;
    assign pt_write_bad = wr_en && (paddr == `CASGEN_ADDR_PT) &&
                          (pwdata[6:0] == pwdata[14:8]);

    // One wait-free access phase: ready rises in the cycle after setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= rd_setup;
            pslverr <= rd_setup & ~mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (rd_setup && !pwrite) begin
                case (paddr)
                    `CASGEN_ADDR_CTRL:   prdata <= {29'h0, ptchk, flow_rtp_en, enable};
                    `CASGEN_ADDR_TOS:    prdata <= {16'h0, sig_tos, data_tos};
                    `CASGEN_ADDR_PT:     prdata <= {9'h0, peer_pt, 1'b0, sig_pt, 1'b0, data_pt};
                    `CASGEN_ADDR_RPT:    prdata <= {16'h0, rpt_ms};
                    `CASGEN_ADDR_REF:    prdata <= {16'h0, ref_ms};
                    `CASGEN_ADDR_STATUS: prdata <= {16'h0, bad_cnt, 4'h0, left,
                                                    state, cfg_err};
                    `CASGEN_ADDR_SEQ:    prdata <= {sig_seq, data_seq};
                    `CASGEN_ADDR_TS:     prdata <= ts;
                    `CASGEN_ADDR_DST_IP: prdata <= flow_dst_ip;
                    `CASGEN_ADDR_SRC_IP: prdata <= flow_src_ip;
                    `CASGEN_ADDR_PORT:   prdata <= {16'h0, flow_dst_port};
                    default:             prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable        <= 1'b0;
            flow_rtp_en   <= 1'b0;
            ptchk         <= 1'b0;
            setup_pulse   <= 1'b0;
            data_tos      <= 8'h00;
            sig_tos       <= 8'h00;
            data_pt       <= `CASGEN_RST_DATA_PT;
            sig_pt        <= `CASGEN_RST_SIG_PT;
            peer_pt       <= `CASGEN_RST_PEER_PT;
            rpt_ms        <= `CASGEN_RST_RPT_MS;
            ref_ms        <= `CASGEN_RST_REF_MS;
            cfg_err       <= 1'b0;
            flow_dst_ip   <= 32'h0000_0000;
            flow_src_ip   <= 32'h0000_0000;
            flow_dst_port <= 16'h0000;
        end else begin
            setup_pulse <= 1'b0;
            // Refused write keeps old data and signaling types but still takes the peer type; set beats a same-cycle clear
            if (wr_en && paddr == `CASGEN_ADDR_STATUS && pwdata[`CASGEN_ST_CFGERR]) begin
                cfg_err <= 1'b0;
            end
            if (pt_write_bad) begin
                cfg_err <= 1'b1;
            end
            if (wr_en) begin
                case (paddr)
                    `CASGEN_ADDR_CTRL: begin
                        enable      <= pwdata[`CASGEN_CTRL_EN];
                        flow_rtp_en <= pwdata[`CASGEN_CTRL_RTP];
                        ptchk       <= pwdata[`CASGEN_CTRL_PTCHK];
                        setup_pulse <= pwdata[`CASGEN_CTRL_SETUP];
                    end
                    `CASGEN_ADDR_TOS: begin
                        data_tos <= pwdata[7:0];
                        sig_tos  <= pwdata[15:8];
                    end
                    `CASGEN_ADDR_PT: begin
                        if (!pt_write_bad) begin
                            data_pt <= pwdata[6:0];
                            sig_pt  <= pwdata[14:8];
                        end
                        peer_pt <= pwdata[22:16];
                    end
                    `CASGEN_ADDR_RPT: rpt_ms <= (pwdata[15:0] == 16'h0) ? 16'h0001
                                                                    : pwdata[15:0];
                    `CASGEN_ADDR_REF: ref_ms <= (pwdata[15:0] == 16'h0) ? 16'h0001
                                                                    : pwdata[15:0];
                    `CASGEN_ADDR_DST_IP: flow_dst_ip <= pwdata;
                    `CASGEN_ADDR_SRC_IP: flow_src_ip <= pwdata;
                    `CASGEN_ADDR_PORT:   flow_dst_port <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Timebases
    // ----------------------------------------
    // Millisecond tick and a shared timestamp for both packet kinds
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_div  <= 32'h0000_0000;
            ts_div  <= 32'h0000_0000;
            ms_tick <= 1'b0;
            ts      <= 32'h0000_0000;
        end else begin
            ms_tick <= (ms_div == MS_CYCLES - 1);
            ms_div  <= (ms_div == MS_CYCLES - 1) ? 32'h0000_0000 : ms_div + 32'h1;
            ts_div  <= (ts_div == TS_CYCLES - 1) ? 32'h0000_0000 : ts_div + 32'h1;
            if (ts_div == TS_CYCLES - 1) begin
                ts <= ts + 32'h1;
            end
        end
    end

    // ----------------------------------------
    // Data packet headers
    // ----------------------------------------
    // Own sequence space; timestamp is the very same register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_seq       <= 16'h0000;
            data_hdr_valid <= 1'b0;
            data_hdr_seq   <= 16'h0000;
            data_hdr_ts    <= 32'h0000_0000;
            data_hdr_tos   <= 8'h00;
            data_hdr_pt    <= 7'h00;
        end else begin
            data_hdr_valid <= data_pkt_req;
            if (data_pkt_req) begin
                data_seq     <= data_seq + 16'h1;
                data_hdr_seq <= data_seq;
                data_hdr_ts  <= ts;
                data_hdr_tos <= data_tos;
                data_hdr_pt  <= flow_rtp_en ? data_pt : 7'h00;
            end
        end
    end

    // ----------------------------------------
    // Change events
    // ----------------------------------------
    // Clears are falling edges of the defect inputs
    assign event_now = enable & (setup_pulse | (cas_signal_bits != cas_prev) |
                                 (lof_prev & ~loss_of_frames) |
                                 (rfl_prev & ~remote_frame_loss));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cas_prev <= {(4*SLOTS){1'b0}};
            lof_prev <= 1'b0;
            rfl_prev <= 1'b0;
        end else begin
            cas_prev <= cas_signal_bits;
            lof_prev <= loss_of_frames;
            rfl_prev <= remote_frame_loss;
        end
    end

    // ----------------------------------------
    // Payload packing
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi = gi + 1) begin : g_pack
            assign pay[PBITS-1-4*gi -: 4] = snap[4*gi +: 4];
        end
        if (SLOTS % 2 == 1) begin : g_pad
            assign pay[3:0] = 4'h0;
        end
    endgenerate

    // Header: type, rtp, pt, tos, seq, ts, 6 spare bits, then payload
    assign word = {`CASGEN_FT_SIG, flow_rtp_en, (flow_rtp_en ? sig_pt : 7'h00),
                   sig_tos, sig_seq, ts, 6'h00, pay};

    // ----------------------------------------
    // Burst and refresh scheduler
    // ----------------------------------------
    assign push = (state == ST_BURST) & due & fifo_ready & ~event_now;

    // A full FIFO stalls the send until space opens
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_IDLE;
            left    <= 2'h0;
            due     <= 1'b0;
            ivl     <= 16'h0000;
            ref_cnt <= 16'h0000;
            snap    <= {(4*SLOTS){1'b0}};
            sig_seq <= 16'h0000;
        end else if (!enable) begin
            state   <= ST_IDLE;
            left    <= 2'h0;
            due     <= 1'b0;
            ivl     <= 16'h0000;
            ref_cnt <= 16'h0000;
        end else if (event_now) begin
            state   <= ST_BURST;
            snap    <= cas_signal_bits;
            left    <= `CASGEN_BURST_LEN;
            due     <= 1'b1;
            ivl     <= 16'h0000;
            ref_cnt <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (ms_tick) begin
                        if (ref_cnt + 16'h1 >= ref_ms) begin
                            state   <= ST_BURST;
                            snap    <= cas_signal_bits;
                            left    <= 2'h1;
                            due     <= 1'b1;
                            ref_cnt <= 16'h0000;
                        end else begin
                            ref_cnt <= ref_cnt + 16'h1;
                        end
                    end
                end
                ST_BURST: begin
                    if (push) begin
                        sig_seq <= sig_seq + 16'h1;
                        left    <= left - 2'h1;
                        due     <= 1'b0;
                        ivl     <= 16'h0000;
                        if (left == 2'h1) begin
                            state   <= ST_IDLE;
                            ref_cnt <= 16'h0000;
                        end
                    end else if (ms_tick && !due) begin
                        if (ivl + 16'h1 >= rpt_ms) begin
                            due <= 1'b1;
                            ivl <= 16'h0000;
                        end else begin
                            ivl <= ivl + 16'h1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Outgoing buffer and output stage
    // ----------------------------------------
    casgen_fifo #(
        .WIDTH (WBITS),
        .DEPTH (4),
        .AW    (2)
    ) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .s_valid (push),
        .s_ready (fifo_ready),
        .s_data  (word),
        .m_valid (f_valid),
        .m_ready (~sig_valid | sig_ready),
        .m_data  (f_data)
    );

    // Output register so the stream leaves straight from flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_valid <= 1'b0;
            sig_data  <= {WBITS{1'b0}};
        end else if (!sig_valid || sig_ready) begin
            sig_valid <= f_valid;
            if (f_valid) begin
                sig_data <= f_data;
            end
        end
    end

    // ----------------------------------------
    // Receive side hold
    // ----------------------------------------
    always @* begin
        rx_ok = rx_valid & ~(ptchk & flow_rtp_en & (rx_pt != peer_pt));
    end

    // Bits change only on an accepted packet, else last value holds
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cas_bits <= {(4*SLOTS){1'b0}};
            bad_cnt     <= 8'h00;
        end else begin
            if (rx_valid && !rx_ok && bad_cnt != 8'hFF) begin
                bad_cnt <= bad_cnt + 8'h1;
            end
            if (rx_ok) begin
                for (k = 0; k < SLOTS; k = k + 1) begin
                    rx_cas_bits[4*k +: 4] <= rx_payload[PBITS-1-4*k -: 4];
                end
            end
        end
    end
endmodule // casgen_sig_framer

// ---- src/casgen_defines.vh ----
`ifndef CASGEN_DEFINES_VH
`define CASGEN_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CASGEN_ADDR_CTRL     8'h00
`define CASGEN_ADDR_TOS      8'h04
`define CASGEN_ADDR_PT       8'h08
`define CASGEN_ADDR_RPT      8'h0C
`define CASGEN_ADDR_REF      8'h10
`define CASGEN_ADDR_STATUS   8'h14
`define CASGEN_ADDR_SEQ      8'h18
`define CASGEN_ADDR_TS       8'h1C
`define CASGEN_ADDR_DST_IP   8'h20
`define CASGEN_ADDR_SRC_IP   8'h24
`define CASGEN_ADDR_PORT     8'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CASGEN_CTRL_EN       0
`define CASGEN_CTRL_RTP      1
`define CASGEN_CTRL_PTCHK    2
`define CASGEN_CTRL_SETUP    3
`define CASGEN_ST_CFGERR     0
`define CASGEN_ST_BURST      1

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CASGEN_FT_SIG        2'h3
`define CASGEN_RST_DATA_PT   7'h60
`define CASGEN_RST_SIG_PT    7'h61
`define CASGEN_RST_PEER_PT   7'h61
`define CASGEN_RST_RPT_MS    16'h0005
`define CASGEN_RST_REF_MS    16'h1388
`define CASGEN_BURST_LEN     2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CASGEN_CLK_PERIOD_NS 4
`define CASGEN_MS_NS         1000000
`define CASGEN_TS_NS         125000
`define CASGEN_MS_CYCLES     (`CASGEN_MS_NS / `CASGEN_CLK_PERIOD_NS)
`define CASGEN_TS_CYCLES     (`CASGEN_TS_NS / `CASGEN_CLK_PERIOD_NS)

`endif

// ---- test/casgen_checker.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module casgen_checker #(
    parameter SLOTS = 3,
    parameter WBITS = 88
) (
    // Clock, reset, bus handshake
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pready,
    // Signaling and headers
    input wire logic [4*SLOTS-1:0] cas_signal_bits,
    input wire logic               data_pkt_req,
    input wire logic               data_hdr_valid,
    input wire logic [15:0]        data_hdr_seq,
    input wire logic               flow_rtp_en,
    input wire logic               sig_valid,
    input wire logic [WBITS-1:0]   sig_data,
    input wire logic               rx_valid,
    input wire logic [4*SLOTS-1:0] rx_cas_bits
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] req_cnt;

    // Requests seen so far, the data sequence number to expect
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            req_cnt <= 16'h0000;
        else if (data_pkt_req)
            req_cnt <= req_cnt + 16'h0001;
    end

    frame_type_a: assert property (sig_valid |-> sig_data[WBITS-1 -: 2] == 2'h3)
        else $error("signaling frame type wrong");
    pad_nibble_a: assert property (sig_valid && SLOTS % 2 == 1 |-> sig_data[3:0] == 4'h0)
        else $error("padding nibble not zero");
    rtp_match_a: assert property (sig_valid |-> sig_data[WBITS-3] == flow_rtp_en)
        else $error("rtp use differs from data flow");
    pt_off_a: assert property (sig_valid && !flow_rtp_en |-> sig_data[WBITS-4 -: 7] == 7'h00)
        else $error("payload type set without rtp");
    data_seq_a: assert property (data_pkt_req |=> data_hdr_valid && data_hdr_seq == $past(req_cnt))
        else $error("data sequence number wrong");
    rx_hold_a: assert property (!rx_valid |=> $stable(rx_cas_bits))
        else $error("held signaling bits moved");
    first_send_a: assert property ($changed(cas_signal_bits) |-> ##[1:44] sig_valid)
        else $error("no packet after signaling change");
    bus_wait_a: assert property (psel && !penable |=> pready)
        else $error("bus access not answered");
    bus_once_a: assert property (pready |=> !pready)
        else $error("ready held too long");
endmodule // casgen_checker

bind casgen_sig_framer casgen_checker #(.SLOTS(SLOTS), .WBITS(WBITS)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .cas_signal_bits(cas_signal_bits), .data_pkt_req(data_pkt_req),
    .data_hdr_valid(data_hdr_valid), .data_hdr_seq(data_hdr_seq), .flow_rtp_en(flow_rtp_en),
    .sig_valid(sig_valid), .sig_data(sig_data), .rx_valid(rx_valid), .rx_cas_bits(rx_cas_bits));

// ---- test/casgen_peer_sink.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Far-side packet sink
// ----------------------------------------
module casgen_peer_sink #(
    parameter WBITS = 88
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             sig_valid,
    input wire logic [WBITS-1:0] sig_data,
    output logic                 sig_ready
);
    logic [WBITS-1:0] pkts[$];
    logic [2:0]       cnt;

    // Stalls two cycles in eight, so the framer must hold its output
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 3'h0;
            sig_ready <= 1'b0;
        end else begin
            cnt <= cnt + 3'h1;
            sig_ready <= cnt != 3'h5 && cnt != 3'h6;
            if (sig_valid && sig_ready)
                pkts.push_back(sig_data);
        end
    end
endmodule // casgen_peer_sink

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb_top;
    localparam WB = 88;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic          lof, rfl, req, dvalid, rtp, sval, srdy, rxv;
    logic [7:0]    paddr, dtos;
    logic [6:0]    rxpt, dpt;
    logic [11:0]   cas, rxb, rxo;
    logic [15:0]   dseq, lfsr, tos, sseq, dport;
    logic [31:0]   pwdata, prdata, rd, dts, dip, sip;
    logic [WB-1:0] sdata, pk;
    int            error_cnt, n_compared;

    casgen_sig_framer #(.SLOTS(3), .MS_CYCLES(20), .TS_CYCLES(5)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cas_signal_bits(cas), .loss_of_frames(lof), .remote_frame_loss(rfl),
        .data_pkt_req(req), .data_hdr_valid(dvalid), .data_hdr_seq(dseq), .data_hdr_ts(dts),
        .data_hdr_tos(dtos), .data_hdr_pt(dpt), .flow_rtp_en(rtp), .flow_dst_ip(dip),
        .flow_src_ip(sip), .flow_dst_port(dport),
        .sig_valid(sval), .sig_ready(srdy), .sig_data(sdata),
        .rx_valid(rxv), .rx_pt(rxpt), .rx_payload(pay(rxb)), .rx_cas_bits(rxo));
    casgen_peer_sink #(.WBITS(WB)) sink (.pclk(pclk), .presetn(presetn), .sig_valid(sval),
        .sig_data(sdata), .sig_ready(srdy));

    always #2 pclk = ~pclk;

    // Expected payload: slot 0 in the top nibble, zero pad last
    function automatic logic [15:0] pay(input logic [11:0] c);
        return {c[3:0], c[7:4], c[11:8], 4'h0};
    endfunction
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One bus transfer; waits for ready, never assumes a count
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'h0;
    endtask
    // Takes n packets from the sink and checks their fields
    task take(input int n, input logic [6:0] pt, input logic [11:0] c);
        repeat (n) begin
            while (sink.pkts.size() == 0) @(posedge pclk);
            pk = sink.pkts.pop_front();
            chk(pk[84:78], pt);
            chk(pk[77:70], tos[15:8]);
            chk(pk[69:54], sseq);
            chk(pk[15:0], pay(c));
            sseq++;
        end
    endtask
    task give_verdict;
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, lof, rfl, req, rxv} = 9'h000;
        {paddr, pwdata, rxpt, rxb, cas} = {8'h00, 32'h0, 7'h00, 12'h000, 12'h5A3};
        {error_cnt, n_compared, lfsr, sseq} = {32'h0, 32'h0, 16'h0004, 16'h0000};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h08, 0);
        chk(rd, 32'h00616160);
        apb(0, 8'h0C, 0);
        chk(rd, 32'h5);
        apb(0, 8'h10, 0);
        chk(rd, 32'h1388);
        apb(0, 8'h2C, 0);
        chk({31'h0, pslverr}, 32'h1);
        chk(rd, 32'h0);
        apb(1, 8'h08, 32'h00212020);
        apb(0, 8'h14, 0);
        chk(rd[0], 1'b1);
        apb(0, 8'h08, 0);
        chk(rd, 32'h00216160);
        // Working set-up: distinct types, random service codes
        lfsr = nxt(lfsr);
        tos = {~lfsr[7:0], lfsr[7:0]};
        apb(1, 8'h08, 32'h00212010);
        apb(1, 8'h04, {16'h0, tos});
        lfsr = nxt(lfsr);
        apb(1, 8'h20, {lfsr, ~lfsr});
        apb(1, 8'h24, {~lfsr, lfsr});
        apb(1, 8'h28, {16'h0, lfsr});
        // Last write lands at the edge the task returns on
        @(posedge pclk);
        chk(dip, {lfsr, ~lfsr});
        chk(sip, {~lfsr, lfsr});
        chk(dport, lfsr);
        apb(1, 8'h0C, 32'h2);
        apb(1, 8'h10, 32'h14);
        // Setup burst without rtp
        apb(1, 8'h00, 32'h1);
        apb(1, 8'h00, 32'h9);
        take(3, 7'h00, cas);
        // Change together with a data header, then a change mid-burst
        apb(1, 8'h00, 32'h3);
        lfsr = nxt(lfsr);
        @(posedge pclk);
        cas <= lfsr[11:0];
        // Header request lands on the edge of the first push
        @(posedge pclk);
        req <= 1'b1;
        @(posedge pclk);
        req <= 1'b0;
        take(1, 7'h20, cas);
        chk(pk[53:22], dts);
        chk(dseq, 16'h0000);
        chk(dtos, tos[7:0]);
        chk(dpt, 7'h10);
        lfsr = nxt(lfsr);
        cas <= lfsr[11:0];
        @(posedge pclk);
        take(3, 7'h20, cas);
        // Clearing of either loss indication
        for (int k = 1; k < 3; k++) begin
            {rfl, lof} <= k[1:0];
            repeat (3) @(posedge pclk);
            {rfl, lof} <= 2'h0;
            take(3, 7'h20, cas);
        end
        take(1, 7'h20, cas);
        // Receive side: accepted, then refused on type
        apb(1, 8'h00, 32'h7);
        lfsr = nxt(lfsr);
        {rxb, rxpt, rxv} <= {lfsr[11:0], 7'h21, 1'b1};
        @(posedge pclk);
        rxv <= 1'b0;
        @(posedge pclk);
        chk(rxo, lfsr[11:0]);
        {rxb, rxpt, rxv} <= {~lfsr[11:0], 7'h22, 1'b1};
        @(posedge pclk);
        rxv <= 1'b0;
        @(posedge pclk);
        chk(rxo, lfsr[11:0]);
        apb(0, 8'h14, 0);
        chk(rd[15:8], 8'h01);
        give_verdict();
    end
endmodule // tb_top
